// file: hdl/glob_regs_pkg.sv
package glob_regs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL       = 6'h02;
    localparam logic [5:0] IDX_TESTER     = 6'h03;
    localparam logic [5:0] IDX_SER_CLK    = 6'h04;
    localparam logic [5:0] IDX_REF_CLK    = 6'h05;
    localparam logic [5:0] IDX_SER_IEN    = 6'h06;
    localparam logic [5:0] IDX_SER_IST    = 6'h07;
    localparam logic [5:0] IDX_ETH_IEN    = 6'h08;
    localparam logic [5:0] IDX_ETH_IST    = 6'h09;
    localparam logic [5:0] IDX_Q_IEN      = 6'h0A;
    localparam logic [5:0] IDX_Q_IST      = 6'h0B;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SOFT_RST   = 0;
    localparam int BIT_IDLE_MODE  = 1;
    localparam int BIT_ATTACH     = 0;
    localparam int BIT_RX_CLK     = 4;
    localparam int BIT_TX_CLK     = 0;
    localparam int BIT_REF_CLK    = 1;
    localparam int BIT_SYS_CLK    = 0;
    localparam int BIT_SER_TX     = 4;
    localparam int BIT_SER_RX     = 0;
    localparam int BIT_ETH        = 0;
    localparam int BIT_TXQ        = 4;
    localparam int BIT_RXQ        = 0;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam int  CLK_PERIOD_NS     = 50;
    localparam int  SOFT_RST_MIN_NS   = 100;
    localparam int  SOFT_RST_CYCLES   =
        (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

    function automatic logic [7:0] byte_addr(input logic [5:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

endpackage : glob_regs_pkg

// file: hdl/global_status_interrupt_regs.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R01) tester attach bit 0 of register 03h connects tester to serial port 1
// (R02) attached: pattern generator drives serial tx, serial rx feeds checker
// (R03) attached: normal ethernet to serial data transfer is suspended
// (R04) attach overrides existing connection; clearing it restores connection
// (R05) in hardware mode the tester is unavailable and attach has no effect
// (R06) serial rx clock activity sets 04h bit 4, cleared by read
// (R07) serial tx clock activity sets 04h bit 0, cleared by read
// (R08) reference clock activity sets 05h bit 1, cleared by read
// (R09) system clock activity sets 05h bit 0, cleared by read
// (R10) 06h bit 4 enables serial tx interrupt status
// (R11) 06h bit 0 enables serial rx interrupt status
// (R12) 07h bit 4 set while serial tx path has enabled event
// (R13) 07h bit 0 set while serial rx path has enabled event
// (R14) 08h bit 0 enables ethernet status summary interrupt
// (R15) ethernet status bit 0 set while mac or mii port has event
// (R16) queue enable bit 4 enables tx queue status interrupt
// (R17) queue enable bit 0 enables rx queue status interrupt
// (R18) queue threshold crossings and overflows raise tx bit 4, rx bit 0
// (R19) interrupt pin drives low when active; idle high or floating
// (R20) soft reset bit clears all registers but itself, held 100 ns
// (R21) interrupt active while any enabled status bit is set
// (R22) one synchronised edge of a monitored clock sets its activity bit
module global_status_interrupt_regs (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // pins
    input  wire logic        hw_mode_pin,
    input  wire logic        rx_serial_clk_pin,
    input  wire logic        tx_serial_clk_pin,
    input  wire logic        reference_clk_pin,
    input  wire logic        system_clock_in,
    input  wire logic        serial_rx_data_pin,
    output logic             serial_tx_data,
    output logic             irq_pin_out,
    output logic             irq_pin_oe,
    // data path
    input  wire logic        norm_tx_data,
    output logic             norm_rx_data,
    input  wire logic        pattern_gen_data,
    output logic             pattern_chk_data,
    output logic             path_suspend,
    // event sources
    input  wire logic        serial_tx_event,
    input  wire logic        serial_rx_event,
    input  wire logic        ethernet_event,
    input  wire logic        txq_threshold,
    input  wire logic        txq_overflow,
    input  wire logic        rxq_threshold,
    input  wire logic        rxq_overflow,
    output logic             soft_reset
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] pin_edge;

    assign pin_raw = {serial_rx_data_pin, hw_mode_pin, system_clock_in,
                      reference_clk_pin, tx_serial_clk_pin,
                      rx_serial_clk_pin};

    // one process for all stages keeps each vector single-driven
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // only the second and third stages are compared
    assign pin_edge = s2_q ^ s3_q;

    // a change only counts once stages two and three agree
    logic hw_mode_q;
    logic ser_rx_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hw_mode_q <= 1'b0;
            ser_rx_q  <= 1'b1;
        end else begin
            if (!pin_edge[4]) begin
                hw_mode_q <= s3_q[4];
            end
            if (!pin_edge[5]) begin
                ser_rx_q <= s3_q[5];
            end
        end
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    glob_regs_pkg::bus_state_t bus_q;
    logic       acc;
    logic       rd_acc;
    logic       wr_acc;
    logic [5:0] idx;
    logic       aligned;

    // one wait cycle: request taken at the second edge
    assign avs_waitrequest = (avs_read | avs_write)
                          && (bus_q != glob_regs_pkg::BUS_ACK);
    assign acc     = (avs_read | avs_write)
                  && (bus_q == glob_regs_pkg::BUS_ACK);
    assign aligned = (avs_address[1:0] == 2'b00);
    assign idx     = avs_address[7:2];
    assign rd_acc  = acc && avs_read && aligned;
    assign wr_acc  = acc && avs_write && aligned && avs_byteenable[0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_q <= glob_regs_pkg::BUS_IDLE;
        end else if (bus_q == glob_regs_pkg::BUS_ACK) begin
            bus_q <= glob_regs_pkg::BUS_IDLE;
        end else if (avs_read | avs_write) begin
            bus_q <= glob_regs_pkg::BUS_ACK;
        end
    end

    function automatic logic hit(input logic       en,
                                 input logic [5:0] a,
                                 input logic [5:0] r);
        hit = en && (a == r);
    endfunction : hit

    // ------------------------------------------------------------
    // soft reset
    // ------------------------------------------------------------
    localparam int RCW = $clog2(glob_regs_pkg::SOFT_RST_CYCLES + 1);
    localparam logic [RCW-1:0] RST_CNT =
        RCW'(glob_regs_pkg::SOFT_RST_CYCLES);
    logic           soft_rst_q;
    logic [RCW-1:0] rst_cnt_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            soft_rst_q <= 1'b0;
        end else if (hit(wr_acc, idx, glob_regs_pkg::IDX_CTRL)) begin
            soft_rst_q <= avs_writedata[glob_regs_pkg::BIT_SOFT_RST];
        end
    end

    // internal reset is stretched to the minimum width
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_q <= '0;
        end else if (soft_rst_q) begin
            rst_cnt_q <= RST_CNT; // R20
        end else if (rst_cnt_q != '0) begin
            rst_cnt_q <= rst_cnt_q - RCW'(1);
        end
    end
    assign soft_reset = soft_rst_q || (rst_cnt_q != '0); // R20

    // ------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------
    logic idle_float_q;
    logic attach_q;
    logic ser_tx_en_q;
    logic ser_rx_en_q;
    logic eth_en_q;
    logic txq_en_q;
    logic rxq_en_q;
    logic [7:0] wd;
    assign wd = avs_writedata[7:0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idle_float_q <= 1'b0;
            attach_q     <= 1'b0;
            ser_tx_en_q  <= 1'b0;
            ser_rx_en_q  <= 1'b0;
            eth_en_q     <= 1'b0;
            txq_en_q     <= 1'b0;
            rxq_en_q     <= 1'b0;
        end else if (soft_reset) begin
            idle_float_q <= 1'b0; // R20
            attach_q     <= 1'b0;
            ser_tx_en_q  <= 1'b0;
            ser_rx_en_q  <= 1'b0;
            eth_en_q     <= 1'b0;
            txq_en_q     <= 1'b0;
            rxq_en_q     <= 1'b0;
        end else if (hit(wr_acc, idx, glob_regs_pkg::IDX_CTRL)) begin
            idle_float_q <= wd[glob_regs_pkg::BIT_IDLE_MODE];
        end else if (hit(wr_acc, idx, glob_regs_pkg::IDX_TESTER)) begin
            attach_q <= wd[glob_regs_pkg::BIT_ATTACH]; // R01
        end else if (hit(wr_acc, idx, glob_regs_pkg::IDX_SER_IEN)) begin
            ser_tx_en_q <= wd[glob_regs_pkg::BIT_SER_TX]; // R10
            ser_rx_en_q <= wd[glob_regs_pkg::BIT_SER_RX]; // R11
        end else if (hit(wr_acc, idx, glob_regs_pkg::IDX_ETH_IEN)) begin
            eth_en_q <= wd[glob_regs_pkg::BIT_ETH]; // R14
        end else if (hit(wr_acc, idx, glob_regs_pkg::IDX_Q_IEN)) begin
            txq_en_q <= wd[glob_regs_pkg::BIT_TXQ]; // R16
            rxq_en_q <= wd[glob_regs_pkg::BIT_RXQ]; // R17
        end
    end

    // ------------------------------------------------------------
    // clock activity latches, set wins over clear-on-read
    // ------------------------------------------------------------
    logic [3:0] seen_q;
    logic       rd_ser_clk;
    logic       rd_ref_clk;
    assign rd_ser_clk = hit(rd_acc, idx, glob_regs_pkg::IDX_SER_CLK);
    assign rd_ref_clk = hit(rd_acc, idx, glob_regs_pkg::IDX_REF_CLK);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            seen_q <= 4'h0;
        end else if (soft_reset) begin
            seen_q <= 4'h0;
        end else begin
            seen_q[0] <= pin_edge[0] | (seen_q[0] & ~rd_ser_clk); // R06 R22
            seen_q[1] <= pin_edge[1] | (seen_q[1] & ~rd_ser_clk); // R07 R22
            seen_q[2] <= pin_edge[2] | (seen_q[2] & ~rd_ref_clk); // R08 R22
            seen_q[3] <= pin_edge[3] | (seen_q[3] & ~rd_ref_clk); // R09 R22
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // serial and ethernet status follow their source summaries
    logic ser_tx_st_q;
    logic ser_rx_st_q;
    logic eth_st_q;
    logic txq_st_q;
    logic rxq_st_q;
    logic rd_q_st;
    assign rd_q_st = hit(rd_acc, idx, glob_regs_pkg::IDX_Q_IST);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ser_tx_st_q <= 1'b0;
            ser_rx_st_q <= 1'b0;
            eth_st_q    <= 1'b0;
        end else if (soft_reset) begin
            ser_tx_st_q <= 1'b0;
            ser_rx_st_q <= 1'b0;
            eth_st_q    <= 1'b0;
        end else begin
            ser_tx_st_q <= serial_tx_event; // R12
            ser_rx_st_q <= serial_rx_event; // R13
            eth_st_q    <= ethernet_event;  // R15
        end
    end

    // queue events are pulses, so they are held until read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            txq_st_q <= 1'b0;
            rxq_st_q <= 1'b0;
        end else if (soft_reset) begin
            txq_st_q <= 1'b0;
            rxq_st_q <= 1'b0;
        end else begin
            txq_st_q <= txq_threshold | txq_overflow
                      | (txq_st_q & ~rd_q_st); // R18
            rxq_st_q <= rxq_threshold | rxq_overflow
                      | (rxq_st_q & ~rd_q_st); // R18
        end
    end

    // ------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------
    logic irq_act;
    assign irq_act = (ser_tx_st_q & ser_tx_en_q) // R10 R21
                   | (ser_rx_st_q & ser_rx_en_q) // R11 R21
                   | (eth_st_q & eth_en_q)       // R14 R21
                   | (txq_st_q & txq_en_q)       // R16 R21
                   | (rxq_st_q & rxq_en_q);      // R17 R21

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_pin_out <= 1'b1;
            irq_pin_oe  <= 1'b1;
        end else begin
            irq_pin_out <= ~irq_act;                // R19
            irq_pin_oe  <= irq_act | ~idle_float_q; // R19
        end
    end

    // ------------------------------------------------------------
    // tester routing
    // ------------------------------------------------------------
    // the normal connection is never torn down, only bypassed, so
    // clearing attach brings it straight back
    logic attached;
    assign attached = attach_q & ~hw_mode_q; // R05

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serial_tx_data   <= 1'b1;
            pattern_chk_data <= 1'b1;
            norm_rx_data     <= 1'b1;
            path_suspend     <= 1'b0;
        end else begin
            serial_tx_data   <= attached ? pattern_gen_data
                                         : norm_tx_data; // R02 R04
            pattern_chk_data <= attached ? ser_rx_q : 1'b1; // R02
            norm_rx_data     <= attached ? 1'b1 : ser_rx_q; // R03 R04
            path_suspend     <= attached; // R03
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (idx == glob_regs_pkg::IDX_CTRL) begin
            rd_mux[glob_regs_pkg::BIT_SOFT_RST]  = soft_rst_q;
            rd_mux[glob_regs_pkg::BIT_IDLE_MODE] = idle_float_q;
        end else if (idx == glob_regs_pkg::IDX_TESTER) begin
            rd_mux[glob_regs_pkg::BIT_ATTACH] = attach_q;
        end else if (idx == glob_regs_pkg::IDX_SER_CLK) begin
            rd_mux[glob_regs_pkg::BIT_RX_CLK] = seen_q[0];
            rd_mux[glob_regs_pkg::BIT_TX_CLK] = seen_q[1];
        end else if (idx == glob_regs_pkg::IDX_REF_CLK) begin
            rd_mux[glob_regs_pkg::BIT_REF_CLK] = seen_q[2];
            rd_mux[glob_regs_pkg::BIT_SYS_CLK] = seen_q[3];
        end else if (idx == glob_regs_pkg::IDX_SER_IEN) begin
            rd_mux[glob_regs_pkg::BIT_SER_TX] = ser_tx_en_q;
            rd_mux[glob_regs_pkg::BIT_SER_RX] = ser_rx_en_q;
        end else if (idx == glob_regs_pkg::IDX_SER_IST) begin
            rd_mux[glob_regs_pkg::BIT_SER_TX] = ser_tx_st_q;
            rd_mux[glob_regs_pkg::BIT_SER_RX] = ser_rx_st_q;
        end else if (idx == glob_regs_pkg::IDX_ETH_IEN) begin
            rd_mux[glob_regs_pkg::BIT_ETH] = eth_en_q;
        end else if (idx == glob_regs_pkg::IDX_ETH_IST) begin
            rd_mux[glob_regs_pkg::BIT_ETH] = eth_st_q;
        end else if (idx == glob_regs_pkg::IDX_Q_IEN) begin
            rd_mux[glob_regs_pkg::BIT_TXQ] = txq_en_q;
            rd_mux[glob_regs_pkg::BIT_RXQ] = rxq_en_q;
        end else if (idx == glob_regs_pkg::IDX_Q_IST) begin
            rd_mux[glob_regs_pkg::BIT_TXQ] = txq_st_q;
            rd_mux[glob_regs_pkg::BIT_RXQ] = rxq_st_q;
        end
        if (!aligned) begin
            rd_mux = 8'h00;
        end
    end
    assign avs_readdata = {24'h000000, rd_mux};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_attach_route: assert property ( // R02
        @(posedge ref_clk) disable iff (!nrst)
        attached |=> serial_tx_data == $past(pattern_gen_data))
        else $error("tester pattern not routed to serial tx");

    a_path_suspend: assert property ( // R03
        @(posedge ref_clk) disable iff (!nrst)
        attached |=> path_suspend && norm_rx_data)
        else $error("normal path not suspended while attached");

    a_hw_mode_block: assert property ( // R05
        @(posedge ref_clk) disable iff (!nrst)
        hw_mode_q |=> !path_suspend)
        else $error("tester attached in hardware mode");

    a_rx_seen_set: assert property ( // R22
        @(posedge ref_clk) disable iff (!nrst || soft_reset)
        pin_edge[0] |=> seen_q[0])
        else $error("rx clock edge did not set activity bit");

    a_cor_clear: assert property ( // R09
        @(posedge ref_clk) disable iff (!nrst)
        rd_ref_clk && !pin_edge[3] |=> !seen_q[3])
        else $error("system clock bit not cleared by read");

    a_queue_hold: assert property ( // R18
        @(posedge ref_clk) disable iff (!nrst || soft_reset)
        txq_overflow ##1 !rd_q_st [*3] |-> txq_st_q)
        else $error("tx queue status lost before read");

    a_irq_drive: assert property ( // R21
        @(posedge ref_clk) disable iff (!nrst)
        (eth_st_q && eth_en_q) |=> irq_pin_oe && !irq_pin_out)
        else $error("enabled ethernet status did not drive pin");

    a_pin_float: assert property ( // R19
        @(posedge ref_clk) disable iff (!nrst)
        !irq_act && idle_float_q |=> !irq_pin_oe)
        else $error("idle pin driven in float mode");

    a_rst_width: assert property ( // R20
        @(posedge ref_clk) disable iff (!nrst)
        $fell(soft_rst_q) |-> soft_reset [*2])
        else $error("soft reset shorter than minimum");

    a_wait_one: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered after one wait cycle");

endmodule : global_status_interrupt_regs

`default_nettype wire

// file: tb/tb_global_status_interrupt_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_global_status_interrupt_regs;
    // --------------------------------------------------------
    // stimulus and observed signals
    // --------------------------------------------------------
    logic        ref_clk = 1'b0, nrst = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, hw_mode_pin = 1'b0;
    logic [3:0]  clk_pins = 4'h0;
    logic        rx_pin = 1'b1, norm_tx_data = 1'b1, gen_data = 1'b0;
    logic [6:0]  ev = 7'h00;
    logic        serial_tx_data, irq_pin_out, irq_pin_oe, norm_rx_data;
    logic        pattern_chk_data, path_suspend, soft_reset;
    logic [7:0]  rd;
    int          err_count = 0;
    int          checks_done = 0;
    // clock pins 0..3: rx serial, tx serial, reference, system
    localparam logic [7:0] CK_A [4] = '{8'h10, 8'h10, 8'h14, 8'h14};
    localparam logic [7:0] CK_M [4] = '{8'h10, 8'h01, 8'h02, 8'h01};
    // events: ser tx, ser rx, eth, txq thr, txq ovf, rxq thr, rxq ovf
    localparam logic [7:0] ST_A [7] = '{8'h1C, 8'h1C, 8'h24, 8'h2C,
                                         8'h2C, 8'h2C, 8'h2C};
    localparam logic [7:0] EN_A [7] = '{8'h18, 8'h18, 8'h20, 8'h28,
                                         8'h28, 8'h28, 8'h28};
    localparam logic [7:0] EV_M [7] = '{8'h10, 8'h01, 8'h01, 8'h10,
                                         8'h10, 8'h01, 8'h01};

    always #25 ref_clk = ~ref_clk;

    global_status_interrupt_regs uut (
        .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .hw_mode_pin(hw_mode_pin), .rx_serial_clk_pin(clk_pins[0]),
        .tx_serial_clk_pin(clk_pins[1]), .reference_clk_pin(clk_pins[2]),
        .system_clock_in(clk_pins[3]), .serial_rx_data_pin(rx_pin),
        .serial_tx_data(serial_tx_data), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe), .norm_tx_data(norm_tx_data),
        .norm_rx_data(norm_rx_data), .pattern_gen_data(gen_data),
        .pattern_chk_data(pattern_chk_data), .path_suspend(path_suspend),
        .serial_tx_event(ev[0]), .serial_rx_event(ev[1]),
        .ethernet_event(ev[2]), .txq_threshold(ev[3]),
        .txq_overflow(ev[4]), .rxq_threshold(ev[5]),
        .rxq_overflow(ev[6]), .soft_reset(soft_reset)
    );

    // --------------------------------------------------------
    // checking and bus tasks
    // --------------------------------------------------------
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic chb(input string nm, input logic s, input logic e);
        chk(nm, {7'h00, s}, {7'h00, e});
    endtask : chb

    // request held until the rising edge that sees waitrequest low;
    // read data taken at that same edge, then released
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [7:0] wd, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, wd};
        avs_write     <= we;
        avs_read      <= ~we;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            give_verdict();
        end
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rck(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, q, e);
    endtask : rck

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        rck("tester", 8'h0C, 8'h00);
        rck("ser_en", 8'h18, 8'h00);
        rck("eth_en", 8'h20, 8'h00);
        rck("q_st", 8'h2C, 8'h00);
        wr(8'h40, 8'hFF);
        rck("unmapped", 8'h40, 8'h00);
        wr(8'h18, 8'hFF);
        rck("ser_en", 8'h18, 8'h11);
        wr(8'h20, 8'hFF);
        rck("eth_en", 8'h20, 8'h01);
        wr(8'h28, 8'hFF);
        avs_byteenable <= 4'h0;
        wr(8'h28, 8'h00);
        avs_byteenable <= 4'hF;
        rck("q_en", 8'h28, 8'h11);
        // soft reset must clear the serial and queue enables written above
        wr(8'h08, 8'h01);
        cyc(1);
        chb("soft_on", soft_reset, 1'b1);
        wr(8'h08, 8'h00);
        cyc(4);
        chb("soft_off", soft_reset, 1'b0);
        rck("ser_en", 8'h18, 8'h00);
        rck("q_en", 8'h28, 8'h00);
        // power-up activity is unknown, so drain both latches first
        bus(1'b0, 8'h10, 8'h00, rd);
        bus(1'b0, 8'h14, 8'h00, rd);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            clk_pins[i] <= ~clk_pins[i];
            cyc(8);
            rck("seen", CK_A[i], CK_M[i]);
            rck("rd_clr", CK_A[i], 8'h00);
        end
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            ev[i] <= 1'b1;
            cyc(3);
            chb("masked", irq_pin_out, 1'b1);
            rck("status", ST_A[i], EV_M[i]);
            wr(EN_A[i], EV_M[i]);
            cyc(3);
            chb("irq_on", irq_pin_out, 1'b0);
            @(posedge ref_clk);
            ev[i] <= 1'b0;
            cyc(3);
            rck("after", ST_A[i], (i > 2) ? EV_M[i] : 8'h00);
            rck("cleared", ST_A[i], 8'h00);
            cyc(3);
            chb("irq_off", irq_pin_out, 1'b1);
            wr(EN_A[i], 8'h00);
        end
        wr(8'h08, 8'h02);
        cyc(3);
        chb("oe_idle", irq_pin_oe, 1'b0);
        @(posedge ref_clk);
        ev[0] <= 1'b1;
        wr(8'h18, 8'h10);
        cyc(3);
        chb("oe_act", irq_pin_oe, 1'b1);
        chb("irq_act", irq_pin_out, 1'b0);
        @(posedge ref_clk);
        ev[0] <= 1'b0;
        rx_pin <= 1'b0;
        cyc(8);
        chb("norm_rx", norm_rx_data, 1'b0);
        chb("chk_idle", pattern_chk_data, 1'b1);
        chb("tx_norm", serial_tx_data, 1'b1);
        wr(8'h0C, 8'h01);
        cyc(2);
        chb("tx_gen", serial_tx_data, 1'b0);
        chb("chk_rx", pattern_chk_data, 1'b0);
        chb("suspend", path_suspend, 1'b1);
        chb("rx_held", norm_rx_data, 1'b1);
        rck("tester", 8'h0C, 8'h01);
        wr(8'h0C, 8'h00);
        cyc(2);
        chb("tx_back", serial_tx_data, 1'b1);
        chb("rx_back", norm_rx_data, 1'b0);
        @(posedge ref_clk);
        hw_mode_pin <= 1'b1;
        cyc(5);
        wr(8'h0C, 8'h01);
        cyc(2);
        chb("hw_susp", path_suspend, 1'b0);
        chb("hw_tx", serial_tx_data, 1'b1);
        give_verdict();
    end
endmodule : tb_global_status_interrupt_regs

`default_nettype wire
